// ### rx_buffer_if.sv
// Connection between the receive controller and its byte store.
`timescale 1ns/100ps
`default_nettype none
interface rx_buffer_if #(parameter int DEPTH = 64);
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_pop;
    logic [7:0] rd_data;
    logic ptr_clear;
    logic [$clog2(DEPTH):0] count;
    modport ctrl (output wr_valid, output wr_data, output rd_pop, output ptr_clear, input rd_data, input count);
    modport store (input wr_valid, input wr_data, input rd_pop, input ptr_clear, output rd_data, output count);
endinterface : rx_buffer_if
`default_nettype wire

// ### rx_buffer_pkg.sv
// Shared register map, field positions and reset values of the receive buffer block.
`default_nettype none
package rx_buffer_pkg;
    localparam logic [6:0] ADDR_STATUS1 = 7'h03;
    localparam logic [6:0] ADDR_STATUS2 = 7'h04;
    localparam logic [6:0] ADDR_ENABLE1 = 7'h05;
    localparam logic [6:0] ADDR_ENABLE2 = 7'h06;
    localparam logic [6:0] ADDR_FUNC_CTRL2 = 7'h08;
    localparam logic [6:0] ADDR_MOD_CTRL2 = 7'h71;
    localparam logic [6:0] ADDR_LEVEL_CTRL = 7'h7e;
    localparam logic [6:0] ADDR_ACCESS = 7'h7f;
    localparam int BIT_PTR_CLEAR = 1;
    localparam int BIT_ALMOST_FULL = 4;
    localparam int BIT_PREAMBLE = 6;
    localparam int BIT_SYNC = 7;
    localparam int BIT_SPI_WRITE = 7;
    localparam int DTMOD_LSB = 4;
    localparam logic [1:0] DTMOD_BUFFERED = 2'h2;
    localparam logic [7:0] FUNC_CTRL2_RESET = 8'h00;
    localparam logic [7:0] FUNC_CTRL2_MASK = 8'h16;
    localparam logic [7:0] LEVEL_CTRL_RESET = 8'h37;
    localparam logic [7:0] LEVEL_CTRL_MASK = 8'h3f;
    localparam logic [7:0] MOD_CTRL2_RESET = 8'h20;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam int BUF_DEPTH = 64;
    localparam int LEVEL_W = 6;
    localparam int SYNC_W = 16;
endpackage : rx_buffer_pkg
`default_nettype wire

// ### rx_buffer_store.sv
// Byte store of the receive buffer with read and write pointers.
`timescale 1ns/100ps
`default_nettype none
module rx_buffer_store #(
    parameter int DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic rst,
    rx_buffer_if.store bus
);
    localparam int AW = $clog2(DEPTH);
    logic [7:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
    logic [AW:0] count;
    logic do_wr, do_rd;

    assign count = wr_ptr_ff - rd_ptr_ff;
    assign bus.count = count;
    assign bus.rd_data = mem[rd_ptr_ff[AW-1:0]];

    always_comb
    begin
        do_wr = bus.wr_valid && (count != (AW+1)'(DEPTH)) && !bus.ptr_clear;
        do_rd = bus.rd_pop && (count != '0) && !bus.ptr_clear;
        nxt_wr_ptr = wr_ptr_ff + (AW+1)'(do_wr);
        nxt_rd_ptr = rd_ptr_ff + (AW+1)'(do_rd);
        if (bus.ptr_clear)
        begin
            // Only the pointers move; the stored bytes stay as they were.
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_ff[AW-1:0]] <= bus.wr_data;
        end
    end

    a_clear_empties: assert property (@(posedge clk_sys) disable iff (rst) bus.ptr_clear |=> count == '0)
        else $error("pointer clear did not empty the buffer");
    a_pop_advances: assert property (@(posedge clk_sys) disable iff (rst)
        bus.rd_pop && !bus.wr_valid && !bus.ptr_clear && count != '0 |=> count == $past(count) - 1'b1)
        else $error("read did not advance the read pointer by one");
    a_empty_holds: assert property (@(posedge clk_sys) disable iff (rst)
        count == '0 && !bus.wr_valid |=> count == '0)
        else $error("read of an empty buffer moved the pointer");
    a_depth_bound: assert property (@(posedge clk_sys) disable iff (rst) count <= (AW+1)'(DEPTH))
        else $error("buffer holds more than its depth");
endmodule : rx_buffer_store
`default_nettype wire

// ### rx_data_handling.sv
// Receive buffer controller: register port, sync qualification, fill level and interrupt pin.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Store 64 received payload bytes for host.
// - Burst reads of access address return bytes.
// - One six-bit programmable almost-full level.
// - Reaching the level raises almost-full interrupt.
// - Pointer clear resets pointers, keeps contents.
// - Disabled events set status, no pin.
// - Sync search only after preamble qualified.
// - Write bytes only after preamble and sync.
// - Direct mode bypasses buffer to pins.
module rx_data_handling #(
    parameter int DEPTH = rx_buffer_pkg::BUF_DEPTH,
    parameter logic [rx_buffer_pkg::SYNC_W-1:0] SYNC_WORD = 16'h3c5a
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_sel_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic demod_bit,
    input wire logic demod_bit_valid,
    input wire logic preamble_valid,
    output logic interrupt_request_pin_n,
    output logic direct_data_out,
    output logic direct_clk_out
);
    localparam int CW = $clog2(DEPTH) + 1;

    rx_buffer_if #(.DEPTH(DEPTH)) buf_bus ();
    rx_buffer_store #(.DEPTH(DEPTH)) u_store (.clk_sys(clk_sys), .rst(rst), .bus(buf_bus));

    logic sclk_q_ff, nxt_sclk_q, addr_phase_ff, nxt_addr_phase, is_write_ff, nxt_is_write;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [6:0] addr_ff, nxt_addr;
    logic [7:0] shift_ff, nxt_shift, tx_ff, nxt_tx;
    logic sdo_ff, nxt_sdo, sdo_oe_ff, nxt_sdo_oe;
    logic [7:0] func_ctrl2_ff, nxt_func_ctrl2, level_ctrl_ff, nxt_level_ctrl, mod_ctrl2_ff, nxt_mod_ctrl2;
    logic [7:0] enable1_ff, nxt_enable1, enable2_ff, nxt_enable2, status1_ff, nxt_status1, status2_ff, nxt_status2;
    logic pop, clr_status1, clr_status2, load, rise, fall;
    logic reload_ff, nxt_reload;
    logic [7:0] byte_in;
    logic [6:0] load_addr;

    logic [rx_buffer_pkg::SYNC_W-1:0] sync_sr_ff, nxt_sync_sr;
    logic in_frame_ff, nxt_in_frame, pre_q_ff, nxt_pre_q, sync_evt, wr_valid;
    logic [7:0] byte_sr_ff, nxt_byte_sr;
    logic [2:0] byte_cnt_ff, nxt_byte_cnt;
    logic dir_data_ff, nxt_dir_data, dir_clk_ff, nxt_dir_clk;
    logic at_level_ff, at_level, af_evt, irq_n_ff, nxt_irq_n, buffered;

    assign buffered = mod_ctrl2_ff[rx_buffer_pkg::DTMOD_LSB +: 2] == rx_buffer_pkg::DTMOD_BUFFERED;
    assign at_level = buf_bus.count >= CW'(level_ctrl_ff[rx_buffer_pkg::LEVEL_W-1:0]);
    assign af_evt = at_level && !at_level_ff;
    assign buf_bus.ptr_clear = func_ctrl2_ff[rx_buffer_pkg::BIT_PTR_CLEAR];
    assign buf_bus.rd_pop = pop;
    assign buf_bus.wr_valid = wr_valid;
    assign buf_bus.wr_data = {byte_sr_ff[6:0], demod_bit};

    function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] head);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            rx_buffer_pkg::ADDR_STATUS1: v = status1_ff;
            rx_buffer_pkg::ADDR_STATUS2: v = status2_ff;
            rx_buffer_pkg::ADDR_ENABLE1: v = enable1_ff;
            rx_buffer_pkg::ADDR_ENABLE2: v = enable2_ff;
            rx_buffer_pkg::ADDR_FUNC_CTRL2: v = func_ctrl2_ff;
            rx_buffer_pkg::ADDR_MOD_CTRL2: v = mod_ctrl2_ff;
            rx_buffer_pkg::ADDR_LEVEL_CTRL: v = level_ctrl_ff;
            rx_buffer_pkg::ADDR_ACCESS: v = head;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    // Register port: first byte is direction and address, then data bytes; the access address does not advance.
    always_comb
    begin
        rise = !spi_sel_n && spi_sclk && !sclk_q_ff;
        fall = !spi_sel_n && !spi_sclk && sclk_q_ff;
        byte_in = {shift_ff[6:0], spi_sdi};
        nxt_sclk_q = spi_sclk;
        nxt_shift = shift_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_addr_phase = addr_phase_ff;
        nxt_is_write = is_write_ff;
        nxt_addr = addr_ff;
        nxt_tx = tx_ff;
        nxt_sdo = sdo_ff;
        nxt_sdo_oe = !spi_sel_n;
        nxt_func_ctrl2 = func_ctrl2_ff;
        nxt_level_ctrl = level_ctrl_ff;
        nxt_mod_ctrl2 = mod_ctrl2_ff;
        nxt_enable1 = enable1_ff;
        nxt_enable2 = enable2_ff;
        load = 1'b0;
        load_addr = addr_ff;
        pop = 1'b0;
        nxt_reload = 1'b0;
        if (spi_sel_n)
        begin
            nxt_bit_cnt = 3'h0;
            nxt_addr_phase = 1'b1;
            nxt_sdo = 1'b0;
        end
        else if (rise)
        begin
            nxt_shift = byte_in;
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7)
            begin
                if (addr_phase_ff)
                begin
                    nxt_addr_phase = 1'b0;
                    nxt_is_write = byte_in[rx_buffer_pkg::BIT_SPI_WRITE];
                    nxt_addr = byte_in[6:0];
                    load = !byte_in[rx_buffer_pkg::BIT_SPI_WRITE];
                    load_addr = byte_in[6:0];
                end
                else
                begin
                    if (addr_ff != rx_buffer_pkg::ADDR_ACCESS)
                    begin
                        nxt_addr = addr_ff + 7'h01;
                    end
                    // An access byte leaves the store once its last bit is out; the next head loads a cycle later.
                    pop = !is_write_ff && addr_ff == rx_buffer_pkg::ADDR_ACCESS;
                    nxt_reload = pop;
                    load = !is_write_ff && !pop;
                    load_addr = nxt_addr;
                    if (is_write_ff)
                    begin
                        case (addr_ff)
                            rx_buffer_pkg::ADDR_ENABLE1: nxt_enable1 = byte_in;
                            rx_buffer_pkg::ADDR_ENABLE2: nxt_enable2 = byte_in;
                            rx_buffer_pkg::ADDR_FUNC_CTRL2: nxt_func_ctrl2 = byte_in & rx_buffer_pkg::FUNC_CTRL2_MASK;
                            rx_buffer_pkg::ADDR_MOD_CTRL2: nxt_mod_ctrl2 = byte_in;
                            rx_buffer_pkg::ADDR_LEVEL_CTRL: nxt_level_ctrl = byte_in & rx_buffer_pkg::LEVEL_CTRL_MASK;
                            default: nxt_enable1 = enable1_ff;
                        endcase
                    end
                end
            end
        end
        else if (fall)
        begin
            nxt_sdo = tx_ff[7];
            nxt_tx = {tx_ff[6:0], 1'b0};
        end
        if (reload_ff)
        begin
            load = 1'b1;
            load_addr = rx_buffer_pkg::ADDR_ACCESS;
        end
        if (load)
        begin
            nxt_tx = read_reg(load_addr, buf_bus.rd_data);
        end
        clr_status1 = load && load_addr == rx_buffer_pkg::ADDR_STATUS1;
        clr_status2 = load && load_addr == rx_buffer_pkg::ADDR_STATUS2;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sclk_q_ff <= 1'b0;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
            addr_phase_ff <= 1'b1;
            is_write_ff <= 1'b0;
            addr_ff <= 7'h00;
            tx_ff <= 8'h00;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
            reload_ff <= 1'b0;
            func_ctrl2_ff <= rx_buffer_pkg::FUNC_CTRL2_RESET;
            level_ctrl_ff <= rx_buffer_pkg::LEVEL_CTRL_RESET;
            mod_ctrl2_ff <= rx_buffer_pkg::MOD_CTRL2_RESET;
            enable1_ff <= rx_buffer_pkg::ENABLE_RESET;
            enable2_ff <= rx_buffer_pkg::ENABLE_RESET;
        end
        else
        begin
            sclk_q_ff <= nxt_sclk_q;
            shift_ff <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
            addr_phase_ff <= nxt_addr_phase;
            is_write_ff <= nxt_is_write;
            addr_ff <= nxt_addr;
            tx_ff <= nxt_tx;
            sdo_ff <= nxt_sdo;
            sdo_oe_ff <= nxt_sdo_oe;
            reload_ff <= nxt_reload;
            func_ctrl2_ff <= nxt_func_ctrl2;
            level_ctrl_ff <= nxt_level_ctrl;
            mod_ctrl2_ff <= nxt_mod_ctrl2;
            enable1_ff <= nxt_enable1;
            enable2_ff <= nxt_enable2;
        end
    end

    // Modem side: sync matching waits for a qualified preamble, then bytes are packed into the store.
    always_comb
    begin
        nxt_pre_q = preamble_valid;
        nxt_sync_sr = sync_sr_ff;
        nxt_in_frame = in_frame_ff;
        nxt_byte_sr = byte_sr_ff;
        nxt_byte_cnt = byte_cnt_ff;
        nxt_dir_data = dir_data_ff;
        nxt_dir_clk = 1'b0;
        sync_evt = 1'b0;
        wr_valid = 1'b0;
        if (!buffered && demod_bit_valid)
        begin
            nxt_dir_data = demod_bit;
            nxt_dir_clk = 1'b1;
        end
        if (!preamble_valid)
        begin
            nxt_sync_sr = '0;
            nxt_in_frame = 1'b0;
            nxt_byte_cnt = 3'h0;
        end
        else if (demod_bit_valid && !in_frame_ff)
        begin
            nxt_sync_sr = {sync_sr_ff[rx_buffer_pkg::SYNC_W-2:0], demod_bit};
            if (nxt_sync_sr == SYNC_WORD)
            begin
                nxt_in_frame = 1'b1;
                sync_evt = 1'b1;
                nxt_byte_cnt = 3'h0;
            end
        end
        else if (demod_bit_valid)
        begin
            nxt_byte_sr = {byte_sr_ff[6:0], demod_bit};
            nxt_byte_cnt = byte_cnt_ff + 3'h1;
            wr_valid = byte_cnt_ff == 3'h7 && buffered;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pre_q_ff <= 1'b0;
            sync_sr_ff <= '0;
            in_frame_ff <= 1'b0;
            byte_sr_ff <= 8'h00;
            byte_cnt_ff <= 3'h0;
            dir_data_ff <= 1'b0;
            dir_clk_ff <= 1'b0;
        end
        else
        begin
            pre_q_ff <= nxt_pre_q;
            sync_sr_ff <= nxt_sync_sr;
            in_frame_ff <= nxt_in_frame;
            byte_sr_ff <= nxt_byte_sr;
            byte_cnt_ff <= nxt_byte_cnt;
            dir_data_ff <= nxt_dir_data;
            dir_clk_ff <= nxt_dir_clk;
        end
    end

    // Status bits: a new event in the cycle of a clearing read wins over the clear.
    always_comb
    begin
        nxt_status1 = clr_status1 ? 8'h00 : status1_ff;
        nxt_status2 = clr_status2 ? 8'h00 : status2_ff;
        nxt_status1[rx_buffer_pkg::BIT_ALMOST_FULL] = nxt_status1[rx_buffer_pkg::BIT_ALMOST_FULL] | af_evt;
        nxt_status2[rx_buffer_pkg::BIT_SYNC] = nxt_status2[rx_buffer_pkg::BIT_SYNC] | sync_evt;
        nxt_status2[rx_buffer_pkg::BIT_PREAMBLE] = nxt_status2[rx_buffer_pkg::BIT_PREAMBLE] | (preamble_valid && !pre_q_ff);
        nxt_irq_n = !(|(status1_ff & enable1_ff) || |(status2_ff & enable2_ff));
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            status1_ff <= 8'h00;
            status2_ff <= 8'h00;
            at_level_ff <= 1'b0;
            irq_n_ff <= 1'b1;
        end
        else
        begin
            status1_ff <= nxt_status1;
            status2_ff <= nxt_status2;
            at_level_ff <= at_level;
            irq_n_ff <= nxt_irq_n;
        end
    end

    assign spi_sdo = sdo_ff;
    assign spi_sdo_oe = sdo_oe_ff;
    assign interrupt_request_pin_n = irq_n_ff;
    assign direct_data_out = dir_data_ff;
    assign direct_clk_out = dir_clk_ff;

    a_masked_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (status1_ff & enable1_ff) == 8'h00 && (status2_ff & enable2_ff) == 8'h00 |=> interrupt_request_pin_n)
        else $error("interrupt pin asserted with no enabled event");
    a_af_raises_pin: assert property (@(posedge clk_sys) disable iff (rst)
        af_evt && enable1_ff[rx_buffer_pkg::BIT_ALMOST_FULL] && $stable(enable1_ff) ##1 $stable(enable1_ff)
        |=> !interrupt_request_pin_n)
        else $error("almost-full event did not reach the interrupt pin");
    a_af_sets_status: assert property (@(posedge clk_sys) disable iff (rst)
        af_evt |=> status1_ff[rx_buffer_pkg::BIT_ALMOST_FULL])
        else $error("almost-full status not set");
    a_write_in_frame: assert property (@(posedge clk_sys) disable iff (rst) wr_valid |-> in_frame_ff && preamble_valid)
        else $error("byte written before preamble and sync");
    a_direct_bypass: assert property (@(posedge clk_sys) disable iff (rst) !buffered |-> !wr_valid)
        else $error("direct mode wrote into the buffer");
    a_sync_gated: assert property (@(posedge clk_sys) disable iff (rst) !preamble_valid |=> sync_sr_ff == '0 && !in_frame_ff)
        else $error("sync search ran without a preamble");
    a_access_pops: assert property (@(posedge clk_sys) disable iff (rst)
        load && load_addr == rx_buffer_pkg::ADDR_ACCESS && buf_bus.count != '0 |=> tx_ff == $past(buf_bus.rd_data))
        else $error("access read did not return the buffer head");
    a_level_event: assert property (@(posedge clk_sys) disable iff (rst)
        $stable(level_ctrl_ff) && buf_bus.count == CW'(level_ctrl_ff[rx_buffer_pkg::LEVEL_W-1:0])
        && $past(buf_bus.count) < buf_bus.count |-> af_evt)
        else $error("level reached without event");
endmodule : rx_data_handling
`default_nettype wire

// ### rx_fifo_data_handling_bench.sv
// Self-checking bench of the receive buffer block driven by the host model and a modem stream.
`timescale 1ns/100ps
`default_nettype none
module rx_fifo_data_handling_bench;
    localparam logic [15:0] SYNC = 16'h9b27;
    logic clk_sys;
    logic rst;
    logic spi_sel_n;
    logic spi_sclk;
    logic spi_sdi;
    logic spi_sdo;
    logic spi_sdo_oe;
    logic demod_bit;
    logic demod_bit_valid;
    logic preamble_valid;
    logic irq_pin_n;
    logic direct_data_out;
    logic direct_clk_out;
    logic dbit;
    logic [7:0] keep;
    logic [7:0] pay [0:127];
    int miscompares;
    int checks_done;
    wire sdo_line = spi_sdo_oe ? spi_sdo : ~spi_sdo;

    rx_data_handling #(.DEPTH(64), .SYNC_WORD(SYNC)) rx_data_handling_inst (
        .clk_sys(clk_sys), .rst(rst), .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .demod_bit(demod_bit), .demod_bit_valid(demod_bit_valid),
        .preamble_valid(preamble_valid), .interrupt_request_pin_n(irq_pin_n),
        .direct_data_out(direct_data_out), .direct_clk_out(direct_clk_out));

    rx_host_model rx_host_model_inst (.clk_sys(clk_sys), .spi_sel_n(spi_sel_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(sdo_line));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        checks_done++;
        if (seen !== want)
        begin
            miscompares++;
            $display("BAD at %0t: %s saw %h expected %h", $time, what, seen, want);
        end
    endtask : check

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rx_host_model_inst.xfer({1'b1, a}, d, 1);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] want, input string what);
        rx_host_model_inst.xfer({1'b0, a}, 8'h00, 1);
        check(rx_host_model_inst.rd_buf[0], want, what);
    endtask : rd_chk

    // Burst read of the access address, compared with the payload sent.
    task automatic drain(input int n);
        rx_host_model_inst.xfer({1'b0, rx_buffer_pkg::ADDR_ACCESS}, 8'h00, n);
        for (int k = 0; k < n; k++)
            check(rx_host_model_inst.rd_buf[k], pay[k], "buffer byte");
    endtask : drain

    task automatic send_bit(input logic b);
        demod_bit = b;
        demod_bit_valid = 1'b1;
        @(negedge clk_sys);
        demod_bit_valid = 1'b0;
        @(negedge clk_sys);
    endtask : send_bit

    // Sync word then n random payload bytes, MSB first, with the preamble flag given.
    task automatic frame(input logic pre, input int n);
        preamble_valid = pre;
        for (int i = 15; i >= 0; i--)
            send_bit(SYNC[i]);
        for (int k = 0; k < n; k++)
        begin
            pay[k] = 8'($urandom);
            for (int i = 7; i >= 0; i--)
                send_bit(pay[k][i]);
        end
        preamble_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : frame

    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial
    begin
        #400000;
        miscompares++;
        give_verdict();
    end

    initial
    begin
        miscompares = 0;
        checks_done = 0;
        rst = 1'b1;
        demod_bit = 1'b0;
        demod_bit_valid = 1'b0;
        preamble_valid = 1'b0;
        void'($urandom(23468));
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        rd_chk(rx_buffer_pkg::ADDR_FUNC_CTRL2, 8'h00, "control reset");
        rd_chk(rx_buffer_pkg::ADDR_LEVEL_CTRL, 8'h37, "level reset");
        rd_chk(7'h2a, 8'h00, "unmapped read");
        wr(rx_buffer_pkg::ADDR_LEVEL_CTRL, 8'hff);
        rd_chk(rx_buffer_pkg::ADDR_LEVEL_CTRL, 8'h3f, "level field width");
        $display("test registers done");
        frame(1'b0, 2);
        rd_chk(rx_buffer_pkg::ADDR_STATUS2, 8'h00, "sync without preamble");
        frame(1'b1, 10);
        rd_chk(rx_buffer_pkg::ADDR_STATUS2, 8'hc0, "preamble and sync");
        drain(10);
        keep = pay[0];
        $display("test qualification done");
        wr(rx_buffer_pkg::ADDR_LEVEL_CTRL, 8'h04);
        frame(1'b1, 4);
        check(8'(irq_pin_n), 8'h01, "masked event pin");
        rd_chk(rx_buffer_pkg::ADDR_STATUS1, 8'h10, "masked event status");
        drain(4);
        wr(rx_buffer_pkg::ADDR_ENABLE1, 8'h10);
        frame(1'b1, 4);
        check(8'(irq_pin_n), 8'h00, "almost full pin");
        rd_chk(rx_buffer_pkg::ADDR_STATUS1, 8'h10, "almost full status");
        check(8'(irq_pin_n), 8'h01, "pin released");
        drain(4);
        $display("test interrupt done");
        frame(1'b1, 3);
        drain(1);
        rd_chk(rx_buffer_pkg::ADDR_ACCESS, pay[1], "next byte after burst");
        wr(rx_buffer_pkg::ADDR_FUNC_CTRL2, 8'h02);
        rd_chk(rx_buffer_pkg::ADDR_FUNC_CTRL2, 8'h02, "clear bit");
        wr(rx_buffer_pkg::ADDR_FUNC_CTRL2, 8'h00);
        rd_chk(rx_buffer_pkg::ADDR_ACCESS, keep, "contents kept");
        frame(1'b1, 1);
        drain(1);
        $display("test pointer clear done");
        rx_host_model_inst.half = 6;
        wr(rx_buffer_pkg::ADDR_ENABLE1, 8'h00);
        wr(rx_buffer_pkg::ADDR_LEVEL_CTRL, 8'h3f);
        frame(1'b1, 65);
        rd_chk(rx_buffer_pkg::ADDR_STATUS1, 8'h10, "level 63 reached");
        drain(64);
        rd_chk(rx_buffer_pkg::ADDR_ACCESS, pay[0], "empty read holds");
        frame(1'b1, 1);
        drain(1);
        wr(rx_buffer_pkg::ADDR_ENABLE2, 8'h80);
        check(8'(irq_pin_n), 8'h00, "sync event pin");
        rd_chk(rx_buffer_pkg::ADDR_STATUS2, 8'hc0, "sync status kept");
        check(8'(irq_pin_n), 8'h01, "sync pin released");
        wr(rx_buffer_pkg::ADDR_ENABLE2, 8'h00);
        $display("test full buffer done");
        rx_host_model_inst.half = 3;
        wr(rx_buffer_pkg::ADDR_MOD_CTRL2, 8'h10);
        preamble_valid = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            dbit = (i < 16) ? SYNC[15 - i] : 1'($urandom);
            demod_bit = dbit;
            demod_bit_valid = 1'b1;
            @(negedge clk_sys);
            check(8'({direct_clk_out, direct_data_out}), {6'h00, 1'b1, dbit}, "direct copy");
            demod_bit_valid = 1'b0;
            @(negedge clk_sys);
        end
        preamble_valid = 1'b0;
        wr(rx_buffer_pkg::ADDR_MOD_CTRL2, 8'h20);
        rd_chk(rx_buffer_pkg::ADDR_ACCESS, pay[1], "direct bypass");
        $display("test direct mode done");
        give_verdict();
    end
endmodule : rx_fifo_data_handling_bench
`default_nettype wire

// ### rx_host_model.sv
// Host controller model that drives the serial register port of the receive buffer block.
`timescale 1ns/100ps
`default_nettype none
module rx_host_model (
    input wire logic clk_sys,
    output logic spi_sel_n,
    output logic spi_sclk,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    // Clock cycles per serial clock phase; the bench raises it to act as a slow host.
    int half = 3;
    logic [7:0] rd_buf [0:127];

    initial
    begin
        spi_sel_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end

    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            spi_sclk = 1'b0;
            spi_sdi = tx[i];
            repeat (half) @(negedge clk_sys);
            spi_sclk = 1'b1;
            rx[i] = spi_sdo;
            repeat (half) @(negedge clk_sys);
        end
    endtask : shift_byte

    // One transaction: command byte, then n data bytes; read bytes land in rd_buf.
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata, input int n);
        logic [7:0] rx;
        spi_sel_n = 1'b0;
        repeat (half) @(negedge clk_sys);
        shift_byte(cmd, rx);
        for (int k = 0; k < n; k++)
        begin
            shift_byte(wdata, rx);
            rd_buf[k] = rx;
        end
        spi_sel_n = 1'b1;
        // A released data line must not keep its last level.
        spi_sdi = ~spi_sdi;
        repeat (half) @(negedge clk_sys);
        spi_sclk = 1'b0;
        repeat (half) @(negedge clk_sys);
    endtask : xfer
endmodule : rx_host_model
`default_nettype wire
